/* File: bench/dmd_decode_sva.sv */
// dmd_decode_sva.sv: checker for the data-memory decoder
// assumes bind onto dmd_decode, one clock domain
`timescale 1ns/1ns
`default_nettype none
module dmd_decode_sva (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_indirect,
    input wire logic acc_stack,
    input wire logic acc_incr,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic xmov_valid,
    input wire logic xmov_write,
    input wire logic xmov_use_pointer,
    input wire logic [7:0] xmov_reg_addr,
    input wire logic xmov_done,
    input wire logic [7:0] port0_out,
    input wire logic [7:0] port2_out,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic latch_pulse_suppress,
    input wire logic internal_xram_disable,
    input wire logic pointer_select,
    input wire logic [15:0] data_pointer
);
// ==========================================
// helpers
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
wire ext = internal_xram_disable | (xmov_use_pointer & (data_pointer > 16'h02FF));
wire xr = xmov_valid & ext & !xmov_write;
sequence ext_read_cycle;
    !read_strobe_n ##1 xmov_done;
endsequence
sequence quiet_bus;
    write_strobe_n & read_strobe_n & $stable(port0_out) & $stable(port2_out);
endsequence
// ==========================================
// assertions
a_ext_read_cycle: assert property (xr |=> ext_read_cycle)
    else $error("external read cycle wrong");
a_ext_write_cycle: assert property (xmov_valid & ext & xmov_write |=> !write_strobe_n & xmov_done)
    else $error("external write cycle wrong");
a_onchip_quiet: assert property (xmov_valid & !ext |=> quiet_bus)
    else $error("on-chip move touched bus");
a_onchip_wr_done: assert property (xmov_valid & !ext & xmov_write |=> xmov_done)
    else $error("on-chip write not done");
a_onchip_rd_done: assert property (xmov_valid & !ext & !xmov_write |-> ##2 xmov_done)
    else $error("on-chip read not done");
a_ptr_address: assert property (xr & xmov_use_pointer |=> {port2_out, port0_out} == $past(data_pointer))
    else $error("pointer address wrong");
a_reg_address: assert property (xr & !xmov_use_pointer |=> port0_out == $past(xmov_reg_addr))
    else $error("register address wrong");
a_stack_internal: assert property (acc_valid & acc_stack |=> write_strobe_n & read_strobe_n)
    else $error("stack access used bus");
a_ctrl_write: assert property (acc_valid & acc_write & !acc_indirect & !acc_stack & acc_addr == 8'h8E
    |-> ##2 internal_xram_disable == $past(acc_wdata[1], 2) && latch_pulse_suppress == $past(acc_wdata[0], 2))
    else $error("control write wrong");
a_indirect_apart: assert property (acc_valid & (acc_indirect | acc_stack) & acc_write
    |-> ##2 $stable(internal_xram_disable) & $stable(pointer_select))
    else $error("indirect write hit register");
a_select_flip: assert property (acc_valid & acc_incr & !acc_write & !acc_indirect & !acc_stack
    & acc_addr == 8'hA2 |-> ##2 pointer_select != $past(pointer_select, 2))
    else $error("select bit not flipped");
a_reset_clean: assert property ($rose(rst_n) |-> read_strobe_n & write_strobe_n & !internal_xram_disable
    & !pointer_select)
    else $error("reset state wrong");
endmodule
`default_nettype wire

/* File: bench/dmd_decode_tb.sv */
// dmd_decode_tb.sv: self-checking bench for the data-memory decoder
// assumes dmd_decode, dmd_ext_mem and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module dmd_decode_tb;
logic core_clk = 0, rst_n = 0, acc_valid = 0, acc_write = 0, acc_indirect = 0, acc_stack = 0, acc_incr = 0;
logic xmov_valid = 0, xmov_write = 0, xmov_use_pointer = 0, ptr_load = 0, ptr_incr = 0;
logic [7:0] acc_addr = 0, acc_wdata = 0, xmov_reg_addr = 0, xmov_wdata = 0, ext_data_in, acc_rdata, xmov_rdata;
logic acc_sfr_other, xmov_done, port0_oe_n, port2_drive, write_strobe_n, read_strobe_n;
logic latch_pulse_suppress, internal_xram_disable, pointer_select;
logic [7:0] port0_out, port2_out, r, d;
logic [15:0] ptr_load_value = 0, data_pointer, lfsr, v;
int err_total = 0, num_checks = 0, rd_count, wr_count, rc;
always #50 core_clk = ~core_clk;
dmd_decode i_dmd_decode (.core_clk, .rst_n, .acc_valid, .acc_write, .acc_indirect, .acc_stack, .acc_addr,
    .acc_wdata, .acc_incr, .xmov_valid, .xmov_write, .xmov_use_pointer, .xmov_reg_addr, .xmov_wdata, .ptr_load,
    .ptr_load_value, .ptr_incr, .ext_data_in, .sfr_ext_rdata_valid(1'b0), .sfr_ext_rdata(8'h00), .acc_rdata,
    .acc_sfr_other, .xmov_rdata, .xmov_done, .port0_out, .port0_oe_n, .port2_out, .port2_drive,
    .write_strobe_n, .read_strobe_n, .latch_pulse_suppress, .internal_xram_disable, .pointer_select, .data_pointer);
dmd_ext_mem i_dmd_ext_mem (.core_clk, .port0_out, .port2_out, .port2_drive, .read_strobe_n, .write_strobe_n,
    .ext_data_in, .rd_count, .wr_count);
// ==========================================
// helpers
function automatic logic [15:0] next_lfsr(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
endfunction
function automatic logic [7:0] exp_ext(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
endfunction
task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
        err_total++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task summarize;
    if (err_total == 0 && num_checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task acc(input logic w, input logic ind, input logic stk, input logic [7:0] a, input logic [7:0] dd, input logic inc);
    @(posedge core_clk) #1;
    {acc_valid, acc_write, acc_indirect, acc_stack, acc_addr, acc_wdata, acc_incr} = {1'b1, w, ind, stk, a, dd, inc};
    @(posedge core_clk) #1;
    acc_valid = 0;
    @(posedge core_clk) #1;
endtask
task ptr(input logic [15:0] val, input logic inc);
    @(posedge core_clk) #1;
    {ptr_load, ptr_incr, ptr_load_value} = {!inc, inc, val};
    @(posedge core_clk) #1;
    {ptr_load, ptr_incr} = 2'b00;
    @(posedge core_clk) #1;
endtask
task xmov(input logic w, input logic p, input logic [7:0] ra, input logic [7:0] wd);
    @(posedge core_clk) #1;
    {xmov_valid, xmov_write, xmov_use_pointer, xmov_reg_addr, xmov_wdata} = {1'b1, w, p, ra, wd};
    @(posedge core_clk) #1;
    xmov_valid = 0;
    for (int i = 0; i < 3 && xmov_done !== 1'b1; i++) @(posedge core_clk) #1;
    chk(xmov_done, 1);
    r = xmov_rdata;
    repeat (3) @(posedge core_clk);
endtask
// ==========================================
// scenarios
initial begin
    lfsr = 16'h0015;
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1;
    chk(internal_xram_disable, 0);
    chk(pointer_select, 0);
    ptr(16'h00FF, 0);
    rc = rd_count + wr_count;
    xmov(1, 1, 8'h00, 8'hA5);
    xmov(0, 0, 8'hFF, 8'h00);
    chk(r, 8'hA5);
    chk(rd_count + wr_count, rc);
    ptr(16'h02FE, 0);
    ptr(16'h0000, 1);
    chk(data_pointer, 16'h02FF);
    xmov(1, 1, 8'h00, 8'h5A);
    xmov(0, 1, 8'h00, 8'h00);
    chk(r, 8'h5A);
    ptr(16'h1234, 0);
    acc(0, 0, 0, 8'hA2, 8'h00, 1);
    chk(pointer_select, 1);
    ptr(16'h4321, 0);
    acc(0, 0, 0, 8'hA2, 8'h00, 1);
    chk(data_pointer, 16'h1234);
    for (int i = 0; i < 10; i++) begin
        lfsr = next_lfsr(lfsr);
        v = lfsr & (i[0] ? 16'hFFFF : 16'h03FF);
        d = lfsr[15:8];
        ptr(v, 0);
        rc = rd_count;
        if (v < 16'h0300) begin
            xmov(1, 1, 8'h00, d);
            xmov(0, 1, 8'h00, 8'h00);
            chk(r, d);
        end else begin
            xmov(0, 1, 8'h00, 8'h00);
            chk(r, exp_ext(v));
        end
        chk(rd_count - rc, v > 16'h02FF);
    end
    acc(1, 1, 0, 8'h8E, 8'h02, 0);
    acc(1, 0, 1, 8'h8E, 8'h02, 0);
    chk(internal_xram_disable, 0);
    acc(0, 1, 0, 8'h8E, 8'h00, 0);
    chk(acc_rdata, 8'h02);
    acc(0, 0, 0, 8'h8E, 8'h00, 0);
    chk(acc_rdata, 8'h00);
    acc(1, 0, 0, 8'h10, d, 0);
    acc(0, 1, 0, 8'h10, 8'h00, 0);
    chk(acc_rdata, d);
    acc(1, 0, 0, 8'h8E, 8'h02, 0);
    chk(internal_xram_disable, 1);
    rc = rd_count;
    xmov(0, 0, 8'h77, 8'h00);
    chk(r, exp_ext(16'h0077));
    chk(rd_count - rc, 1);
    ptr(16'h0010, 0);
    rc = wr_count;
    xmov(1, 1, 8'h00, 8'h66);
    chk(wr_count - rc, 1);
    summarize;
end
initial begin
    #400000;
    err_total++;
    summarize;
end
endmodule
bind dmd_decode dmd_decode_sva i_dmd_decode_sva (.core_clk, .rst_n, .acc_valid, .acc_write, .acc_indirect,
    .acc_stack, .acc_incr, .acc_addr, .acc_wdata, .xmov_valid, .xmov_write, .xmov_use_pointer, .xmov_reg_addr,
    .xmov_done, .port0_out, .port2_out, .write_strobe_n, .read_strobe_n, .latch_pulse_suppress,
    .internal_xram_disable, .pointer_select, .data_pointer);
`default_nettype wire

/* File: bench/dmd_ext_mem.sv */
// dmd_ext_mem.sv: external data memory on the port bus
// assumes read data is sampled while the read strobe is low
`timescale 1ns/1ns
`default_nettype none
module dmd_ext_mem (
    input wire logic core_clk,
    input wire logic [7:0] port0_out,
    input wire logic [7:0] port2_out,
    input wire logic port2_drive,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    output logic [7:0] ext_data_in,
    output int rd_count,
    output int wr_count
);
logic [7:0] last = 8'h00;
// ==========================================
// data pattern from address, garbage when idle
always @* begin
    if (!read_strobe_n)
        ext_data_in = port0_out ^ (port2_drive ? port2_out : 8'h00) ^ 8'h3C;
    else
        ext_data_in = ~last;
end
always @(posedge core_clk) begin
    last <= ext_data_in;
    if (!read_strobe_n) rd_count <= rd_count + 1;
    if (!write_strobe_n) wr_count <= wr_count + 1;
end
initial begin
    rd_count = 0;
    wr_count = 0;
end
endmodule
`default_nettype wire

/* File: hdl/dmd_decode.v */
// dmd_decode.v: internal data-memory decode, expanded RAM, dual data pointers, external bus select
// assumes the core issues one access per cycle on the same clock; results appear two cycles later
// Function
// [RULE1] lower RAM 00H-7FH answers direct and indirect accesses
// [RULE2] upper RAM 80H-FFH answers indirect accesses only
// [RULE3] special registers at 80H-FFH answer direct accesses only
// [RULE4] above 7FH: indirect goes to upper RAM, direct to special register
// [RULE5] upper RAM and special registers are separate storage
// [RULE6] with disable bit 0, external moves to 000H-2FFH use on-chip RAM
// [RULE7] on-chip expanded RAM accesses leave ports and strobes untouched
// [RULE8] disable bit 0, pointer moves at 0300H and above run external bus cycle
// [RULE9] disable bit 0, register moves reach 00H-FFH on chip, no strobes
// [RULE10] disable bit 1, every external move goes to the external bus
// [RULE11] register-indirect external move drives 8-bit address on port 0; code does so on reads only, writes drive the write data on port 0
// [RULE12] pointer external move drives high byte port 2, low byte port 0; on writes the code drives the write data on port 0 instead
// [RULE13] stack accesses use only the 256 internal bytes
// [RULE14] two 16-bit pointers; select bit 0 first, 1 second
// [RULE15] incrementing the pointer control register flips the select bit
// [RULE16] memory control register at 8EH: disable bit 1, suppress bit 0
// [RULE17] software writes zero to reserved bits 7 to 2
// [RULE18] pointer control register at A2H, resets 00H, bit 2 reads zero
// [RULE19] reset clears the disable bit, expanded RAM mapped in
`timescale 1ns/1ns
`default_nettype none
`include "dmd_regs.vh"
module dmd_decode (
    input wire core_clk,
    input wire rst_n,
    input wire acc_valid,
    input wire acc_write,
    input wire acc_indirect,
    input wire acc_stack,
    input wire [7:0] acc_addr,
    input wire [7:0] acc_wdata,
    input wire acc_incr,
    input wire xmov_valid,
    input wire xmov_write,
    input wire xmov_use_pointer,
    input wire [7:0] xmov_reg_addr,
    input wire [7:0] xmov_wdata,
    input wire ptr_load,
    input wire [15:0] ptr_load_value,
    input wire ptr_incr,
    input wire [7:0] ext_data_in,
    input wire sfr_ext_rdata_valid,
    input wire [7:0] sfr_ext_rdata,
    output reg [7:0] acc_rdata,
    output reg acc_sfr_other,
    output reg [7:0] xmov_rdata,
    output reg xmov_done,
    output reg [7:0] port0_out,
    output reg port0_oe_n,
    output reg [7:0] port2_out,
    output reg port2_drive,
    output reg write_strobe_n,
    output reg read_strobe_n,
    output reg latch_pulse_suppress,
    output reg internal_xram_disable,
    output reg pointer_select,
    output reg [15:0] data_pointer
);
    reg [7:0] lower_ram [0:127];
    reg [7:0] upper_ram [0:127];
    reg [7:0] aux_memory_control;
    reg [7:0] aux_pointer_control;
    reg [15:0] data_pointer_first;
    reg [15:0] data_pointer_second;
    reg [7:0] ram_rdata;
    reg [7:0] sfr_rdata;
    reg sfr_hit;
    reg rd_from_sfr;
    reg xram_rd_pending;
    reg ram_valid_q;
    reg sfr_own_q;
    reg [7:0] sfr_q;
    wire [15:0] sel_pointer;
    wire is_upper;
    wire is_sfr;
    wire [15:0] xmov_addr;
    wire xmov_onchip;
    wire [7:0] xram_rdata;
    wire xram_we;
    wire [7:0] pctl_read;
    reg [7:0] next_pctl;
    wire sfr_access;
    wire wr_mem_ctl;
    wire upd_ptr_ctl;
    wire wr_ptr_byte;
    wire ext_move;
    wire ext_read;

    // ==========================================
    // helpers
    function [7:0] pctl_view;
        input [7:0] raw;
        begin
            pctl_view = {4'h0, raw[`DMD_USER_FLAG_BIT], 1'b0, 1'b0, raw[`DMD_POINTER_SELECT_BIT]};
        end
    endfunction

    function [15:0] ptr_pick;
        input sel;
        input [15:0] first;
        input [15:0] second;
        begin
            ptr_pick = sel ? second : first;
        end
    endfunction

    // load wins over increment, increment over a byte write
    function [15:0] ptr_next;
        input [15:0] cur;
        input load;
        input [15:0] load_value;
        input incr;
        input high_byte;
        input [7:0] wdata;
        begin
            if (load) begin
                ptr_next = load_value;
            end else if (incr) begin
                ptr_next = cur + 16'h0001;
            end else if (high_byte) begin
                ptr_next = {wdata, cur[7:0]};
            end else begin
                ptr_next = {cur[15:8], wdata};
            end
        end
    endfunction

    // ==========================================
    // address space decode
    assign is_upper = acc_addr > `DMD_LOWER_RAM_LAST;
    // stack is always an indirect internal access
    assign is_sfr = is_upper && !acc_indirect && !acc_stack; // [RULE3] [RULE4] [RULE13]
    assign pctl_read = pctl_view(aux_pointer_control); // [RULE18]
    assign sel_pointer = ptr_pick(aux_pointer_control[`DMD_POINTER_SELECT_BIT],
                                  data_pointer_first, data_pointer_second); // [RULE14]

    // ==========================================
    // direct register strobes
    assign sfr_access = acc_valid && is_sfr;
    assign wr_mem_ctl = sfr_access && acc_write && acc_addr == `DMD_AUX_MEMORY_CONTROL_ADDR; // [RULE16]
    assign upd_ptr_ctl = sfr_access && (acc_write || acc_incr) && acc_addr == `DMD_AUX_POINTER_CONTROL_ADDR;
    assign wr_ptr_byte = sfr_access && acc_write &&
                         (acc_addr == `DMD_PTR_FIRST_LOW_ADDR || acc_addr == `DMD_PTR_FIRST_HIGH_ADDR);

    // ==========================================
    // internal RAM, lower and upper banks
    always @(posedge core_clk) begin
        if (acc_valid && !is_sfr) begin
            if (acc_write) begin
                if (is_upper) begin
                    upper_ram[acc_addr[6:0]] <= acc_wdata; // [RULE2] [RULE5]
                end else begin
                    lower_ram[acc_addr[6:0]] <= acc_wdata; // [RULE1]
                end
            end
            ram_rdata <= is_upper ? upper_ram[acc_addr[6:0]] : lower_ram[acc_addr[6:0]];
        end
    end

    // ==========================================
    // special register read decode
    always @* begin
        sfr_hit = 1'b1;
        sfr_rdata = 8'h00;
        case (acc_addr)
            `DMD_AUX_MEMORY_CONTROL_ADDR: sfr_rdata = {6'h00, aux_memory_control[1:0]};
            `DMD_AUX_POINTER_CONTROL_ADDR: sfr_rdata = pctl_read;
            `DMD_PTR_FIRST_LOW_ADDR: sfr_rdata = sel_pointer[7:0];
            `DMD_PTR_FIRST_HIGH_ADDR: sfr_rdata = sel_pointer[15:8];
            default: sfr_hit = 1'b0;
        endcase
    end

    // increment adds one to the visible value, bit 1 absorbs the carry
    always @* begin
        next_pctl = aux_pointer_control;
        if (acc_write) begin
            next_pctl = acc_wdata;
        end else if (acc_incr) begin
            next_pctl = pctl_read + 8'h01; // [RULE15]
        end
    end

    // ==========================================
    // memory control register
    always @(posedge core_clk) begin
        if (!rst_n) begin
            aux_memory_control <= `DMD_AUX_MEMORY_CONTROL_RST; // [RULE19]
        end else if (wr_mem_ctl) begin
            // reserved bits are not stored; software keeps them zero
            aux_memory_control <= {6'h00, acc_wdata[1:0]}; // [RULE16] [RULE17]
        end
    end

    // ==========================================
    // pointer control register
    always @(posedge core_clk) begin
        if (!rst_n) begin
            aux_pointer_control <= `DMD_AUX_POINTER_CONTROL_RST; // [RULE18]
        end else if (upd_ptr_ctl) begin
            aux_pointer_control <= {4'h0, next_pctl[`DMD_USER_FLAG_BIT], 2'b00,
                                    next_pctl[`DMD_POINTER_SELECT_BIT]}; // [RULE15] [RULE18]
        end
    end

    // ==========================================
    // data pointers, only the selected one moves
    always @(posedge core_clk) begin
        if (!rst_n) begin
            data_pointer_first <= 16'h0000;
            data_pointer_second <= 16'h0000;
        end else if (ptr_load || ptr_incr || wr_ptr_byte) begin
            if (aux_pointer_control[`DMD_POINTER_SELECT_BIT]) begin
                data_pointer_second <= ptr_next(data_pointer_second, ptr_load, ptr_load_value,
                                                ptr_incr, acc_addr[0], acc_wdata); // [RULE14]
            end else begin
                data_pointer_first <= ptr_next(data_pointer_first, ptr_load, ptr_load_value,
                                               ptr_incr, acc_addr[0], acc_wdata); // [RULE14]
            end
        end
    end

    // ==========================================
    // direct access bookkeeping
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rd_from_sfr <= 1'b0;
            acc_sfr_other <= 1'b0;
        end else begin
            rd_from_sfr <= sfr_access;
            acc_sfr_other <= sfr_access && !sfr_hit;
        end
    end

    // ==========================================
    // read data to the core
    always @(posedge core_clk) begin
        if (!rst_n) begin
            acc_rdata <= 8'h00;
        end else if (ram_valid_q) begin
            acc_rdata <= ram_rdata; // [RULE1] [RULE2]
        end else if (sfr_own_q) begin
            acc_rdata <= sfr_q; // [RULE3] [RULE5]
        end else if (rd_from_sfr && sfr_ext_rdata_valid) begin
            acc_rdata <= sfr_ext_rdata;
        end
    end

    // ==========================================
    // external move routing
    assign xmov_addr = xmov_use_pointer ? sel_pointer : {8'h00, xmov_reg_addr}; // [RULE11] [RULE12]
    assign xmov_onchip = !aux_memory_control[`DMD_XRAM_DISABLE_BIT] &&
                         xmov_addr <= `DMD_XRAM_LAST; // [RULE6] [RULE9] [RULE10]
    assign xram_we = xmov_valid && xmov_write && xmov_onchip;
    assign ext_move = xmov_valid && !xmov_onchip; // [RULE8] [RULE10]
    assign ext_read = ext_move && !xmov_write;

    dmd_xram u_xram (
        .core_clk(core_clk),
        .we(xram_we),
        .addr(xmov_addr[`DMD_XRAM_AW-1:0]),
        .wdata(xmov_wdata),
        .rdata(xram_rdata)
    );

    always @(posedge core_clk) begin
        if (!rst_n) begin
            port0_out <= 8'h00;
            port0_oe_n <= 1'b1;
            port2_out <= 8'h00;
            port2_drive <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
        end else begin
            write_strobe_n <= !(ext_move && xmov_write); // [RULE8] [RULE10]
            read_strobe_n <= !ext_read; // [RULE8] [RULE10]
            if (ext_move) begin // [RULE7]
                port0_out <= xmov_write ? xmov_wdata : xmov_addr[7:0]; // [RULE8] [RULE11]
                port0_oe_n <= !xmov_write;
                if (xmov_use_pointer) begin
                    port2_out <= xmov_addr[15:8]; // [RULE12]
                    port2_drive <= 1'b1;
                end
            end else if (!xmov_valid) begin
                // bus released on idle cycles; on-chip moves leave it alone
                port0_oe_n <= 1'b1;
                port2_drive <= 1'b0;
            end
        end
    end

    // ==========================================
    // external move completion
    always @(posedge core_clk) begin
        if (!rst_n) begin
            xram_rd_pending <= 1'b0;
            xmov_done <= 1'b0;
            xmov_rdata <= 8'h00;
        end else begin
            xram_rd_pending <= xmov_valid && !xmov_write && xmov_onchip;
            // writes finish at once, reads once their data is in
            xmov_done <= (xmov_valid && xmov_write) || xram_rd_pending || !read_strobe_n; // [RULE6]
            if (xram_rd_pending) begin
                xmov_rdata <= xram_rdata; // [RULE6]
            end else if (!read_strobe_n) begin
                // sampled while the read strobe is still low
                xmov_rdata <= ext_data_in; // [RULE8]
            end
        end
    end

    // ==========================================
    // visible state
    always @(posedge core_clk) begin
        if (!rst_n) begin
            latch_pulse_suppress <= 1'b0;
            internal_xram_disable <= 1'b0;
            pointer_select <= 1'b0;
            data_pointer <= 16'h0000;
        end else begin
            latch_pulse_suppress <= aux_memory_control[`DMD_LATCH_SUPPRESS_BIT]; // [RULE16]
            internal_xram_disable <= aux_memory_control[`DMD_XRAM_DISABLE_BIT];
            pointer_select <= aux_pointer_control[`DMD_POINTER_SELECT_BIT];
            data_pointer <= sel_pointer;
        end
    end

    // ==========================================
    // read data return
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ram_valid_q <= 1'b0;
            sfr_own_q <= 1'b0;
            sfr_q <= 8'h00;
        end else begin
            ram_valid_q <= acc_valid && !is_sfr && !acc_write;
            sfr_own_q <= sfr_access && sfr_hit && !acc_write;
            sfr_q <= sfr_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/dmd_regs.vh */
// dmd_regs.vh: address map, field positions and reset values of the data-memory decoder
// assumes inclusion by hdl/dmd_decode.v and hdl/dmd_xram.v
`ifndef DMD_REGS_VH
`define DMD_REGS_VH
// ==========================================
// register addresses
`define DMD_AUX_MEMORY_CONTROL_ADDR 8'h8E
`define DMD_AUX_POINTER_CONTROL_ADDR 8'hA2
`define DMD_PTR_FIRST_LOW_ADDR 8'h82
`define DMD_PTR_FIRST_HIGH_ADDR 8'h83
// ==========================================
// field positions
`define DMD_XRAM_DISABLE_BIT 1
`define DMD_LATCH_SUPPRESS_BIT 0
`define DMD_POINTER_SELECT_BIT 0
`define DMD_USER_FLAG_BIT 3
// ==========================================
// reset values
`define DMD_AUX_MEMORY_CONTROL_RST 8'h00
`define DMD_AUX_POINTER_CONTROL_RST 8'h00
// ==========================================
// address space limits
`define DMD_LOWER_RAM_LAST 8'h7F
`define DMD_XRAM_LAST 16'h02FF
`define DMD_XRAM_DEPTH 768
`define DMD_XRAM_AW 10
`endif

/* File: hdl/dmd_xram.v */
// dmd_xram.v: 768-byte on-chip expanded data RAM, one synchronous port
// assumes caller keeps addresses below 768
`timescale 1ns/1ns
`default_nettype none
`include "dmd_regs.vh"
module dmd_xram (
    input wire core_clk,
    input wire we,
    input wire [`DMD_XRAM_AW-1:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:`DMD_XRAM_DEPTH-1];
    // ==========================================
    // storage
    always @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire
